// *** timer_pair_pkg.sv ***
// Purpose: constants for the cascaded 8-bit timer pair block.
// Assumes: AXI4-Lite register access, 32-bit data, 8-bit registers.
// Notes: channels 0/1 form pair 0, channels 2/3 form pair 1.
//
// Overview of operation
// - clock select 100 in either channel of a pair cascades the pair.
// - upper select 100: one 16-bit counter, upper channel high byte.
// - same cascade for channels 2 (high byte) and 3 (low byte).
// - 16-bit mode: upper flag on 16-bit match, lower on low-byte match.
// - 16-bit mode: upper pin on 16-bit match, lower pin on byte match.
// - 16-bit capture sets match-B flags of both channels together.
// - 16-bit capture loads full count into both match-B registers.
// - 16-bit capture edge chosen by upper channel B-level bits only.
// - 16-bit clear uses upper clear select; lower byte never clears alone.
// - upper wrap flag sets when 16-bit count rolls FFFF to 0000.
// - lower wrap flag sets when its own byte rolls FF to 00.
// - lower select 100: lower counts upper channel match-A events.
// - compare-match count mode: each channel uses only its own settings.
// - both channels selecting 100 stops both counters.
// - 8-bit capture copies counter to match-B on chosen edge.
// - three gated interrupt sources per channel, separate request lines.
// - source priority: match-A, then match-B, then wrap.
// - shared vectors: ch1 A/B, ch3 A/B, wrap of 0/1, wrap of 2/3.
// - flag clears only by read-while-1 then write 0; writing 1 no effect.
// - capture edge code: 00 rising, 01 falling, 10 both, 11 none.
// - same-cycle matches: toggle over 1 over 0 over no change.
package timer_pair_pkg;
	localparam int NUM_CH = 4;
	// register indices within one channel window, four bytes apart
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_STATUS = 3'h1;
	localparam logic [2:0] IDX_COUNT = 3'h2;
	localparam logic [2:0] IDX_MATCH_A = 3'h3;
	localparam logic [2:0] IDX_MATCH_B = 3'h4;
	localparam logic [7:0] CH_STRIDE = 8'h20;
	// control register fields
	localparam int CTRL_IE_B = 7;
	localparam int CTRL_IE_A = 6;
	localparam int CTRL_IE_WRAP = 5;
	localparam int CTRL_CLR_LO = 3;
	localparam int CTRL_CKS_LO = 0;
	// status register fields
	localparam int ST_FLAG_LO = 5;
	localparam int ST_CAP_EN = 4;
	localparam int ST_BSEL_LO = 2;
	localparam int ST_ASEL_LO = 0;
	// clock select codes
	localparam logic [2:0] CKS_DIV8 = 3'h1;
	localparam logic [2:0] CKS_DIV64 = 3'h2;
	localparam logic [2:0] CKS_DIV8192 = 3'h3;
	localparam logic [2:0] CKS_CASCADE = 3'h4;
	// clear select codes
	localparam logic [1:0] CLR_MATCH_A = 2'h1;
	localparam logic [1:0] CLR_MATCH_B = 2'h2;
	localparam logic [1:0] CLR_CAPTURE = 2'h3;
	// capture edge codes
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;
	// output actions, numeric order equals priority
	localparam logic [1:0] ACT_DRIVE0 = 2'h1;
	localparam logic [1:0] ACT_DRIVE1 = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	// reset values
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_MATCH = 8'hFF;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] BYTE_MAX = 8'hFF;
	// prescaler taps, divide ratios minus one
	localparam logic [12:0] PRE_DIV8 = 13'h0007;
	localparam logic [12:0] PRE_DIV64 = 13'h003F;
	localparam logic [12:0] PRE_DIV8192 = 13'h1FFF;
	// top pending source codes
	localparam logic [1:0] TOP_NONE = 2'h0;
	localparam logic [1:0] TOP_A = 2'h1;
	localparam logic [1:0] TOP_B = 2'h2;
	localparam logic [1:0] TOP_WRAP = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** timer_pair.sv ***
// Purpose: four 8-bit up-counters in two cascadable pairs, AXI4-Lite regs.
// Assumes: pins synchronous to clk_i; srst_i synchronous active high.
// Notes: odd channels own the two-way capture/compare pins.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module timer_pair (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [1:0] compare_out_pin_o,
	input wire logic [1:0] capture_io_pin_i,
	output logic [1:0] capture_io_pin_o,
	output logic [1:0] capture_io_oe_n_o,
	output logic [3:0] match_a_irq_o,
	output logic [3:0] match_b_irq_o,
	output logic [3:0] wrap_irq_o,
	output logic [1:0] shared_ab_irq_o,
	output logic [1:0] wrap_interrupt_o,
	output logic [7:0] irq_top_o
);
	logic [7:0] ctrl_reg [4];
	logic [4:0] cfg_reg [4];
	logic [2:0] flag_reg [4];
	logic [2:0] arm_reg [4];
	logic [7:0] cnt_reg [4];
	logic [7:0] ma_reg [4];
	logic [7:0] mb_reg [4];
	logic [3:0] pin_reg;
	logic [1:0] cap_prev_reg;
	logic [12:0] pre_reg;
	logic [3:0] tick, mat_a, mat_b, clr, ovf, cap;
	logic [7:0] cap_val [4];
	logic [1:0] casc16, cmc;
	logic aw_held_reg, w_held_reg;
	logic [7:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb0_reg;
	logic wr_fire, wr_ok, rd_ok;
	logic [1:0] wr_ch;
	logic [2:0] wr_idx;
	logic [3:0] wr_sel [5];
	logic [7:0] rd_byte;

	// free-running prescaler shared by all channels
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pre_reg <= 13'h0000;
		end else begin
			pre_reg <= pre_reg + 13'h0001;
		end
	end

	function automatic logic pre_en(input logic [2:0] cks,
		input logic [12:0] pre);
		case (cks)
			timer_pair_pkg::CKS_DIV8: pre_en =
				((pre & timer_pair_pkg::PRE_DIV8) ==
				timer_pair_pkg::PRE_DIV8);
			timer_pair_pkg::CKS_DIV64: pre_en =
				((pre & timer_pair_pkg::PRE_DIV64) ==
				timer_pair_pkg::PRE_DIV64);
			timer_pair_pkg::CKS_DIV8192: pre_en =
				(pre == timer_pair_pkg::PRE_DIV8192);
			default: pre_en = 1'b0;
		endcase
	endfunction

	function automatic logic edge_hit(input logic [1:0] sel,
		input logic now, input logic prev);
		case (sel)
			timer_pair_pkg::EDGE_RISE: edge_hit = now & ~prev;
			timer_pair_pkg::EDGE_FALL: edge_hit = ~now & prev;
			timer_pair_pkg::EDGE_BOTH: edge_hit = now ^ prev;
			default: edge_hit = 1'b0; // unused code
		endcase
	endfunction

	// pair-level event logic: ticks, matches, clears, wraps, captures
	always_comb begin
		logic [2:0] cu, cl;
		logic capture_enable, ev, tl, tu, m16a, m16b, c16;
		logic [1:0] esel, cclr;
		cu = 3'h0;
		cl = 3'h0;
		capture_enable = 1'b0;
		ev = 1'b0;
		tl = 1'b0;
		tu = 1'b0;
		m16a = 1'b0;
		m16b = 1'b0;
		c16 = 1'b0;
		esel = 2'h0;
		cclr = 2'h0;
		tick = 4'h0;
		mat_a = 4'h0;
		mat_b = 4'h0;
		clr = 4'h0;
		ovf = 4'h0;
		cap = 4'h0;
		casc16 = 2'h0;
		cmc = 2'h0;
		for (int k = 0; k < 2; k++) begin
			cap_val[2*k] = cnt_reg[2*k];
			cap_val[2*k+1] = cnt_reg[2*k+1];
			cu = ctrl_reg[2*k][2:0];
			cl = ctrl_reg[2*k+1][2:0];
			// both at 100 leaves neither mode: no clock at all
			casc16[k] = (cu == timer_pair_pkg::CKS_CASCADE) &&
				(cl != timer_pair_pkg::CKS_CASCADE);
			cmc[k] = (cl == timer_pair_pkg::CKS_CASCADE) &&
				(cu != timer_pair_pkg::CKS_CASCADE);
			capture_enable = cfg_reg[2*k+1][timer_pair_pkg::ST_CAP_EN];
			// edge from upper bits in 16-bit mode, lower bits ignored
			esel = casc16[k] ? cfg_reg[2*k][3:2] :
				cfg_reg[2*k+1][3:2];
			ev = capture_enable && edge_hit(esel, capture_io_pin_i[k],
				cap_prev_reg[k]);
			if (casc16[k]) begin
				tl = pre_en(cl, pre_reg);
				tu = tl && (cnt_reg[2*k+1] == timer_pair_pkg::BYTE_MAX);
				m16a = tl && ({cnt_reg[2*k], cnt_reg[2*k+1]} ==
					{ma_reg[2*k], ma_reg[2*k+1]});
				m16b = tl && !capture_enable && ({cnt_reg[2*k], cnt_reg[2*k+1]} ==
					{mb_reg[2*k], mb_reg[2*k+1]});
				cclr = ctrl_reg[2*k][4:3];
				c16 = (cclr == timer_pair_pkg::CLR_MATCH_A && m16a) ||
					(cclr == timer_pair_pkg::CLR_MATCH_B && m16b) ||
					(cclr == timer_pair_pkg::CLR_CAPTURE && ev);
				tick[2*k] = tu;
				tick[2*k+1] = tl;
				mat_a[2*k] = m16a;
				mat_b[2*k] = m16b;
				mat_a[2*k+1] = tl && (cnt_reg[2*k+1] == ma_reg[2*k+1]);
				mat_b[2*k+1] = tl && !capture_enable &&
					(cnt_reg[2*k+1] == mb_reg[2*k+1]);
				clr[2*k] = c16;
				clr[2*k+1] = c16; // lower byte never clears alone
				ovf[2*k] = tu && !c16 &&
					(cnt_reg[2*k] == timer_pair_pkg::BYTE_MAX);
				ovf[2*k+1] = tl && !c16 &&
					(cnt_reg[2*k+1] == timer_pair_pkg::BYTE_MAX);
				cap[2*k] = ev; // both flags together
				cap[2*k+1] = ev;
			end else begin
				// independent channels, own settings only
				tick[2*k] = pre_en(cu, pre_reg);
				mat_a[2*k] = tick[2*k] && (cnt_reg[2*k] == ma_reg[2*k]);
				mat_b[2*k] = tick[2*k] && (cnt_reg[2*k] == mb_reg[2*k]);
				tick[2*k+1] = cmc[k] ? mat_a[2*k] :
					pre_en(cl, pre_reg);
				mat_a[2*k+1] = tick[2*k+1] &&
					(cnt_reg[2*k+1] == ma_reg[2*k+1]);
				mat_b[2*k+1] = tick[2*k+1] && !capture_enable &&
					(cnt_reg[2*k+1] == mb_reg[2*k+1]);
				cap[2*k+1] = ev;
				for (int j = 0; j < 2; j++) begin
					cclr = ctrl_reg[2*k+j][4:3];
					clr[2*k+j] =
						(cclr == timer_pair_pkg::CLR_MATCH_A &&
						mat_a[2*k+j]) ||
						(cclr == timer_pair_pkg::CLR_MATCH_B &&
						mat_b[2*k+j]) ||
						(cclr == timer_pair_pkg::CLR_CAPTURE &&
						cap[2*k+j]);
					ovf[2*k+j] = tick[2*k+j] && !clr[2*k+j] &&
						(cnt_reg[2*k+j] == timer_pair_pkg::BYTE_MAX);
				end
			end
		end
	end

	// capture pin history for edge detection
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cap_prev_reg <= 2'h0;
		end else begin
			cap_prev_reg <= capture_io_pin_i;
		end
	end

	// write decode: a write fires once both halves have been taken
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_ch = awaddr_reg[6:5];
	assign wr_idx = awaddr_reg[4:2];
	assign wr_ok = !awaddr_reg[7] && (wr_idx <= timer_pair_pkg::IDX_MATCH_B);
	assign rd_ok = !s_axi_araddr[7] &&
		(s_axi_araddr[4:2] <= timer_pair_pkg::IDX_MATCH_B);
	always_comb begin
		for (int r = 0; r < 5; r++) begin
			wr_sel[r] = 4'h0;
			for (int c = 0; c < 4; c++) begin
				wr_sel[r][c] = wr_fire && wr_ok && wstrb0_reg &&
					(wr_ch == 2'(c)) && (wr_idx == 3'(r));
			end
		end
	end

	// write address and data channels, taken in either order
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= timer_pair_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready &&
				s_axi_awvalid;
			s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? timer_pair_pkg::RESP_OKAY :
					timer_pair_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
			end
		end
	end

	// read mux, upper bits of the word read as zero
	always_comb begin
		logic [1:0] c;
		c = s_axi_araddr[6:5];
		case (s_axi_araddr[4:2])
			timer_pair_pkg::IDX_CTRL: rd_byte = ctrl_reg[c];
			timer_pair_pkg::IDX_STATUS: rd_byte = {flag_reg[c], cfg_reg[c]};
			timer_pair_pkg::IDX_COUNT: rd_byte = cnt_reg[c];
			timer_pair_pkg::IDX_MATCH_A: rd_byte = ma_reg[c];
			timer_pair_pkg::IDX_MATCH_B: rd_byte = mb_reg[c];
			default: rd_byte = 8'h00;
		endcase
	end

	// read channel: one cycle from address acceptance to data
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= timer_pair_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready &&
				s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_ok ? rd_byte : 8'h00};
				s_axi_rresp <= rd_ok ? timer_pair_pkg::RESP_OKAY :
					timer_pair_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// per-channel registers, flags and pins
	for (genvar ch = 0; ch < 4; ch++) begin : g_ch
		logic rd_status;
		logic [2:0] set_v, clr_v;
		logic [1:0] act_a, act_b, act;
		assign rd_status = s_axi_arvalid && s_axi_arready && rd_ok &&
			(s_axi_araddr[6:5] == 2'(ch)) &&
			(s_axi_araddr[4:2] == timer_pair_pkg::IDX_STATUS);
		assign set_v = {mat_b[ch] | cap[ch], mat_a[ch], ovf[ch]};
		// only bits armed by an earlier read and written as 0 clear
		assign clr_v = wr_sel[timer_pair_pkg::IDX_STATUS][ch] ?
			(arm_reg[ch] & ~wdata_reg[7:5]) : 3'h0;

		// settings written by software steer the counting logic
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				ctrl_reg[ch] <= timer_pair_pkg::RST_CTRL;
				cfg_reg[ch] <= 5'h00;
				ma_reg[ch] <= timer_pair_pkg::RST_MATCH;
			end else begin
				if (wr_sel[timer_pair_pkg::IDX_CTRL][ch]) begin
					ctrl_reg[ch] <= wdata_reg;
				end
				if (wr_sel[timer_pair_pkg::IDX_STATUS][ch]) begin
					cfg_reg[ch] <= wdata_reg[4:0];
				end
				if (wr_sel[timer_pair_pkg::IDX_MATCH_A][ch]) begin
					ma_reg[ch] <= wdata_reg;
				end
			end
		end

		// counter: write beats clear, clear beats increment
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				cnt_reg[ch] <= timer_pair_pkg::RST_COUNT;
			end else if (wr_sel[timer_pair_pkg::IDX_COUNT][ch]) begin
				cnt_reg[ch] <= wdata_reg;
			end else if (clr[ch]) begin
				cnt_reg[ch] <= timer_pair_pkg::RST_COUNT;
			end else if (tick[ch]) begin
				cnt_reg[ch] <= cnt_reg[ch] + 8'h01;
			end
		end

		// match-B register, capture wins over a software write
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				mb_reg[ch] <= timer_pair_pkg::RST_MATCH;
			end else if (cap[ch]) begin
				mb_reg[ch] <= cap_val[ch];
			end else if (wr_sel[timer_pair_pkg::IDX_MATCH_B][ch]) begin
				mb_reg[ch] <= wdata_reg;
			end
		end

		// sticky flags: a set in the clearing cycle survives
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				flag_reg[ch] <= 3'h0;
				arm_reg[ch] <= 3'h0;
			end else begin
				flag_reg[ch] <= set_v | (flag_reg[ch] & ~clr_v);
				if (wr_sel[timer_pair_pkg::IDX_STATUS][ch]) begin
					arm_reg[ch] <= 3'h0;
				end else if (rd_status) begin
					arm_reg[ch] <= arm_reg[ch] | flag_reg[ch];
				end
			end
		end

		// pin action, higher code wins when A and B coincide
		assign act_a = mat_a[ch] ? cfg_reg[ch][1:0] : 2'h0;
		assign act_b = mat_b[ch] ? cfg_reg[ch][3:2] : 2'h0;
		assign act = (act_a > act_b) ? act_a : act_b;
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				pin_reg[ch] <= 1'b0;
			end else begin
				case (act)
					timer_pair_pkg::ACT_DRIVE0: pin_reg[ch] <= 1'b0;
					timer_pair_pkg::ACT_DRIVE1: pin_reg[ch] <= 1'b1;
					timer_pair_pkg::ACT_TOGGLE: pin_reg[ch] <= ~pin_reg[ch];
					default: pin_reg[ch] <= pin_reg[ch];
				endcase
			end
		end

		// requests follow flag and enable one cycle later
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				match_a_irq_o[ch] <= 1'b0;
				match_b_irq_o[ch] <= 1'b0;
				wrap_irq_o[ch] <= 1'b0;
				irq_top_o[2*ch+1:2*ch] <= timer_pair_pkg::TOP_NONE;
			end else begin
				match_a_irq_o[ch] <= flag_reg[ch][1] &&
					ctrl_reg[ch][timer_pair_pkg::CTRL_IE_A];
				match_b_irq_o[ch] <= flag_reg[ch][2] &&
					ctrl_reg[ch][timer_pair_pkg::CTRL_IE_B];
				wrap_irq_o[ch] <= flag_reg[ch][0] &&
					ctrl_reg[ch][timer_pair_pkg::CTRL_IE_WRAP];
				if (flag_reg[ch][1] &&
					ctrl_reg[ch][timer_pair_pkg::CTRL_IE_A]) begin
					irq_top_o[2*ch+1:2*ch] <= timer_pair_pkg::TOP_A;
				end else if (flag_reg[ch][2] &&
					ctrl_reg[ch][timer_pair_pkg::CTRL_IE_B]) begin
					irq_top_o[2*ch+1:2*ch] <= timer_pair_pkg::TOP_B;
				end else if (flag_reg[ch][0] &&
					ctrl_reg[ch][timer_pair_pkg::CTRL_IE_WRAP]) begin
					irq_top_o[2*ch+1:2*ch] <= timer_pair_pkg::TOP_WRAP;
				end else begin
					irq_top_o[2*ch+1:2*ch] <= timer_pair_pkg::TOP_NONE;
				end
			end
		end
	end

	// pins and shared vectors per pair
	for (genvar k = 0; k < 2; k++) begin : g_pair
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				compare_out_pin_o[k] <= 1'b0;
				capture_io_pin_o[k] <= 1'b0;
				capture_io_oe_n_o[k] <= 1'b0;
				shared_ab_irq_o[k] <= 1'b0;
				wrap_interrupt_o[k] <= 1'b0;
			end else begin
				compare_out_pin_o[k] <= pin_reg[2*k];
				capture_io_pin_o[k] <= pin_reg[2*k+1];
				// pin turns to input while capture is enabled
				capture_io_oe_n_o[k] <=
					cfg_reg[2*k+1][timer_pair_pkg::ST_CAP_EN];
				shared_ab_irq_o[k] <= (flag_reg[2*k+1][1] &&
					ctrl_reg[2*k+1][timer_pair_pkg::CTRL_IE_A]) ||
					(flag_reg[2*k+1][2] &&
					ctrl_reg[2*k+1][timer_pair_pkg::CTRL_IE_B]);
				wrap_interrupt_o[k] <= (flag_reg[2*k][0] &&
					ctrl_reg[2*k][timer_pair_pkg::CTRL_IE_WRAP]) ||
					(flag_reg[2*k+1][0] &&
					ctrl_reg[2*k+1][timer_pair_pkg::CTRL_IE_WRAP]);
			end
		end

		a_stop_both: assert property (@(posedge clk_i)
			disable iff (srst_i)
			(ctrl_reg[2*k][2:0] == timer_pair_pkg::CKS_CASCADE &&
			ctrl_reg[2*k+1][2:0] == timer_pair_pkg::CKS_CASCADE)
			|-> (tick[2*k] == 1'b0 && tick[2*k+1] == 1'b0))
			else $error("counter ticked with both selects at cascade");
		a_cap_full16: assert property (@(posedge clk_i)
			disable iff (srst_i)
			(casc16[k] && cap[2*k+1]) |=> ({mb_reg[2*k], mb_reg[2*k+1]} ==
			$past({cnt_reg[2*k], cnt_reg[2*k+1]})) &&
			flag_reg[2*k][2] && flag_reg[2*k+1][2])
			else $error("16-bit capture did not load both bytes");
		a_clear_both16: assert property (@(posedge clk_i)
			disable iff (srst_i)
			(casc16[k] && clr[2*k] && !wr_sel[timer_pair_pkg::IDX_COUNT][2*k]
			&& !wr_sel[timer_pair_pkg::IDX_COUNT][2*k+1])
			|=> (cnt_reg[2*k] == 8'h00 && cnt_reg[2*k+1] == 8'h00))
			else $error("16-bit clear left a byte set");
		a_wrap16: assert property (@(posedge clk_i)
			disable iff (srst_i)
			(casc16[k] && tick[2*k+1] && !clr[2*k] &&
			cnt_reg[2*k] == 8'hFF && cnt_reg[2*k+1] == 8'hFF)
			|=> flag_reg[2*k][0] && flag_reg[2*k+1][0])
			else $error("16-bit rollover missed a wrap flag");
		a_cmc_count: assert property (@(posedge clk_i)
			disable iff (srst_i)
			(cmc[k] && mat_a[2*k] && !clr[2*k+1] &&
			!wr_sel[timer_pair_pkg::IDX_COUNT][2*k+1])
			|=> cnt_reg[2*k+1] == $past(cnt_reg[2*k+1]) + 8'h01)
			else $error("lower channel missed a match-A count");
		a_cap8_copy: assert property (@(posedge clk_i)
			disable iff (srst_i)
			(!casc16[k] && cap[2*k+1]) |=> mb_reg[2*k+1] ==
			$past(cnt_reg[2*k+1]) && flag_reg[2*k+1][2])
			else $error("8-bit capture did not copy the counter");
		a_shared_ab: assert property (@(posedge clk_i)
			disable iff (srst_i)
			(match_a_irq_o[2*k+1] || match_b_irq_o[2*k+1])
			== shared_ab_irq_o[k])
			else $error("shared match vector disagrees with its sources");
		c_mode16: cover property (@(posedge clk_i) casc16[k] && cap[2*k]);
		c_modecmc: cover property (@(posedge clk_i) cmc[k] && tick[2*k+1]);
	end

	// channel 2 is checked here; the bench enables match-A requests on channels 2 and 3
	a_irq_follow: assert property (@(posedge clk_i)
		disable iff (srst_i)
		(flag_reg[2][1] && ctrl_reg[2][timer_pair_pkg::CTRL_IE_A])
		|=> match_a_irq_o[2])
		else $error("match-A request did not follow flag and enable");
	a_irq_drop: assert property (@(posedge clk_i)
		disable iff (srst_i)
		!flag_reg[2][1] |=> !match_a_irq_o[2])
		else $error("match-A request stayed up after its flag cleared");
	a_write1_keeps: assert property (@(posedge clk_i)
		disable iff (srst_i)
		(flag_reg[0][0] && wr_sel[timer_pair_pkg::IDX_STATUS][0] &&
		wdata_reg[timer_pair_pkg::ST_FLAG_LO]) |=> flag_reg[0][0])
		else $error("writing one cleared a flag");
	a_pin_toggle: assert property (@(posedge clk_i)
		disable iff (srst_i)
		(mat_a[3] && cfg_reg[3][1:0] == timer_pair_pkg::ACT_TOGGLE)
		|=> pin_reg[3] != $past(pin_reg[3]))
		else $error("toggle action lost to a lower one");
	c_clear_flag: cover property (@(posedge clk_i)
		arm_reg[0][1] ##1 !flag_reg[0][1]);
endmodule

// *** cap_pin_model.sv ***
// Purpose: far-side model of the two capture/compare pins.
// Assumes: pin level set by the bench just after a rising edge.
// Notes: resolves the two-way pin from the device enable.
`timescale 1ns/1ns
module cap_pin_model (
	input wire logic [1:0] oe_n_i,
	input wire logic [1:0] drive_i,
	input wire logic [1:0] level_i,
	output logic [1:0] pin_o
);
	// device drive wins while enabled, else the far side's level
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pin_o[i] = oe_n_i[i] ? level_i[i] : drive_i[i];
		end
	end
endmodule

// *** cascaded_8bit_timer_pair_tb_top.sv ***
// Purpose: self-checking bench for the cascaded timer pair.
// Assumes: registers reached only through the AXI4-Lite tasks.
// Notes: capture pulses held 3 clocks to meet the minimum width.
`timescale 1ns/1ns
module cascaded_8bit_timer_pair_tb_top;
	logic clk_i, srst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, irq_top_o;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, match_a_irq_o, match_b_irq_o, wrap_irq_o;
	logic [1:0] s_axi_bresp, s_axi_rresp, compare_out_pin_o, lvl;
	logic [1:0] capture_io_pin_i, capture_io_pin_o, capture_io_oe_n_o;
	logic [1:0] shared_ab_irq_o, wrap_interrupt_o;
	int errors, samples_checked;
	timer_pair uut (.*);
	cap_pin_model pins (.oe_n_i(capture_io_oe_n_o),
		.drive_i(capture_io_pin_o), .level_i(lvl), .pin_o(capture_io_pin_i));
	// free-running 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	function automatic logic [7:0] ad(input logic [7:0] ch, logic [2:0] i);
		return ch * timer_pair_pkg::CH_STRIDE + {3'h0, i, 2'h0};
	endfunction
	// valids drop only at the edge that saw their ready
	task automatic wr(input logic [7:0] a, d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		// bready left high: a following call must not flip it twice
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic rchk(input string n, input logic [7:0] a, e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(n, d, {24'h0, e});
	endtask
	// pin level held three clocks so the edge is seen
	task automatic pin(input logic v);
		lvl[0] <= v;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic t_cascade();
		wr(ad(0, 2), 8'hFF);
		wr(ad(1, 2), 8'hFE);
		wr(ad(0, 0), 8'h24);
		wr(ad(1, 0), 8'h01);
		repeat (40) @(posedge clk_i);
		chk("wrap_irq0", wrap_irq_o[0], 1'b1);
		chk("wrap_irq1", wrap_irq_o[1], 1'b0);
		chk("wrap_vec", wrap_interrupt_o[0], 1'b1);
		chk("top0", irq_top_o[1:0], timer_pair_pkg::TOP_WRAP);
		rchk("hi_byte", ad(0, 2), 8'h00);
		rchk("lo_wrap", ad(1, 1), 8'hE0);
		rchk("hi_wrap", ad(0, 1), 8'hE0);
		wr(ad(1, 0), 8'h00);
		wr(ad(0, 1), 8'h20);
		wr(ad(0, 1), 8'h00);
		rchk("keep", ad(0, 1), 8'h20);
		wr(ad(0, 1), 8'h00);
		rchk("clear", ad(0, 1), 8'h00);
		chk("irq_off", wrap_irq_o[0], 1'b0);
	endtask
	task automatic t_capture();
		wr(ad(0, 0), 8'h00);
		wr(ad(1, 2), 8'h5A);
		wr(ad(1, 1), 8'h10);
		pin(1'b1);
		pin(1'b0);
		chk("oe_n", capture_io_oe_n_o[0], 1'b1);
		rchk("cap8", ad(1, 4), 8'h5A);
		rchk("capf", ad(1, 1), 8'h90);
		wr(ad(1, 2), 8'h33);
		wr(ad(1, 1), 8'h14);
		pin(1'b1);
		rchk("no_rise", ad(1, 4), 8'h5A);
		pin(1'b0);
		rchk("fall", ad(1, 4), 8'h33);
		wr(ad(0, 0), 8'h1C);
		wr(ad(0, 2), 8'h12);
		wr(ad(1, 2), 8'h34);
		wr(ad(0, 1), 8'h04);
		wr(ad(1, 1), 8'h10);
		pin(1'b1);
		rchk("lo_edge", ad(1, 4), 8'h33);
		pin(1'b0);
		rchk("cap_hi", ad(0, 4), 8'h12);
		rchk("cap_lo", ad(1, 4), 8'h34);
		rchk("hi_flag", ad(0, 1), 8'h84);
		rchk("clr16", ad(1, 2), 8'h00);
	endtask
	// pair 1 in compare-match count mode, A and B matching together
	task automatic t_cmc();
		wr(ad(3, 0), 8'hC4);
		wr(ad(3, 3), 8'h02);
		wr(ad(3, 4), 8'h02);
		wr(ad(3, 1), 8'h07);
		wr(ad(2, 3), 8'h01);
		wr(ad(2, 1), 8'h03);
		wr(ad(2, 0), 8'h49);
		while (!shared_ab_irq_o[1]) begin
			@(posedge clk_i);
		end
		chk("irq_a3", match_a_irq_o[3], 1'b1);
		chk("irq_b3", match_b_irq_o[3], 1'b1);
		chk("ab_vec0", shared_ab_irq_o[0], 1'b0);
		chk("top3", irq_top_o[7:6], timer_pair_pkg::TOP_A);
		chk("irq_a2", match_a_irq_o[2], 1'b1);
		chk("pin2", compare_out_pin_o[1], 1'b1);
		chk("pin3", capture_io_pin_o[1], 1'b1);
		chk("oe_n3", capture_io_oe_n_o[1], 1'b0);
		rchk("cmc_cnt", ad(3, 2), 8'h03);
		rchk("cmc_st", ad(3, 1), 8'hC7);
	endtask
	// both channels cascading: no count clock at all
	task automatic t_stop();
		wr(ad(1, 2), 8'h10);
		wr(ad(1, 0), 8'h04);
		repeat (30) @(posedge clk_i);
		rchk("stop_lo", ad(1, 2), 8'h10);
		rchk("stop_hi", ad(0, 2), 8'h00);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// watchdog: far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		final_report();
	end
	// reset, then the scenarios in order
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, lvl} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		srst_i = 1'b1;
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		rchk("rst_ma", ad(0, 3), timer_pair_pkg::RST_MATCH);
		rd(8'h80, d, r);
		chk("unmapped", r, timer_pair_pkg::RESP_SLVERR);
		t_cascade();
		t_capture();
		t_stop();
		t_cmc();
		final_report();
	end
endmodule
